// File: bcs_pkg.sv
`default_nettype none
package bcs_pkg;
  // register addresses and entry point
  localparam logic [7:0]  SFR_FLAGS_ADDR = 8'hDD;
  localparam logic [15:0] XD_STAT_ADDR   = 16'h11FF;
  localparam logic [15:0] RAM_ENTRY_ADDR = 16'h0000;
  // reset values and good-status values
  localparam logic [7:0] FLAGS_RST     = 8'h00;
  localparam logic [7:0] STAT_RST      = 8'h00;
  localparam logic [7:0] STAT_OK_PLAIN = 8'h00;
  localparam logic [7:0] STAT_OK_STRAP = 8'h80;
  localparam logic [7:0] FORCE_VALUE   = 8'h20;
  // software may not write the done and fail flags
  localparam logic [7:0] FLAGS_SW_MASK = 8'hF9;
  // flag register bit positions
  localparam int FL_RUN_SYS = 0;
  localparam int FL_DONE    = 1;
  localparam int FL_FAIL    = 2;
  localparam int FL_RUN_POR = 4;
  localparam int FL_FORCE   = 5;
  // status byte bit positions
  localparam int ST_FIRST_ERR = 0;
  localparam int ST_NEXT_ERR  = 1;
  localparam int ST_FAC_LSB   = 2;
  localparam int ST_FAC_MSB   = 4;
  localparam int ST_STRAP     = 7;
  // program levels and load kinds
  localparam logic [1:0] PROG_FACTORY = 2'h0;
  localparam logic [1:0] PROG_USER    = 2'h1;
  localparam logic [1:0] PROG_RUN     = 2'h2;
  localparam logic [1:0] LOAD_FACTORY = 2'h0;
  localparam logic [1:0] LOAD_FIRST   = 2'h1;
  localparam logic [1:0] LOAD_NEXT    = 2'h2;
  // strap sampling delay covers the pin synchroniser
  localparam int         SYNC_STAGES = 2;
  localparam logic [1:0] STRAP_WAIT  = 2'h2;
endpackage
`default_nettype wire

// File: bcs_reg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface bcs_reg_if;
  logic       done_set;
  logic       fail_set;
  logic       restart;
  logic [7:0] flags;
  modport core (output done_set, output fail_set, output restart, input flags);
  modport regs (input done_set, input fail_set, input restart, output flags);
endinterface
`default_nettype wire

// File: bcs_sync.sv
`timescale 1ns/10ps
`default_nettype none
module bcs_sync (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic pin_in,
  output logic      pin_sync
);
  typedef struct packed {
    logic meta;
    logic sync;
  } bcs_sync_t;
  bcs_sync_t q;
  bcs_sync_t d;

  // two-stage shift, first stage only feeds the second
  always_comb begin
    d      = q;
    d.meta = pin_in;
    d.sync = q.meta;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign pin_sync = q.sync;
endmodule
`default_nettype wire

// File: bcs_sfr.sv
`timescale 1ns/10ps
`default_nettype none
module bcs_sfr (
  input  wire logic  clk_sys,
  input  wire logic  nrst,
  input  wire logic  ce,
  input  wire logic [7:0] sfr_addr,
  input  wire logic  sfr_we,
  input  wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  bcs_reg_if.regs    rif
);
  import bcs_pkg::*;
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] rdata;
  } bcs_sfr_t;
  bcs_sfr_t q;
  bcs_sfr_t d;
  logic     hit;

  assign hit = (sfr_addr == SFR_FLAGS_ADDR);

  // system restart, software write, then hardware sets win last
  always_comb begin
    d = q;
    if (rif.restart) begin
      d.flags           = FLAGS_RST;
      d.flags[FL_FORCE] = q.flags[FL_FORCE]; // survives until power-on reset
    end
    if (sfr_we && hit) begin
      // debug host forces run bits through here
      d.flags = (sfr_wdata & FLAGS_SW_MASK) | (d.flags & ~FLAGS_SW_MASK);
    end
    d.flags[FL_DONE] = d.flags[FL_DONE] | rif.done_set;
    d.flags[FL_FAIL] = d.flags[FL_FAIL] | rif.fail_set;
    d.rdata          = hit ? q.flags : 8'h00;
  end

  // every flag bit including reserved ones clears at power-on
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign rif.flags = q.flags;
  assign sfr_rdata = q.rdata;

  force_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && rif.restart && !sfr_we |=> rif.flags[FL_FORCE] == $past(rif.flags[FL_FORCE]))
    else $error("force bit lost on system restart");
  sw_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && sfr_we && hit && sfr_wdata == FORCE_VALUE |=> rif.flags[FL_FORCE])
    else $error("force write not stored");
endmodule
`default_nettype wire

// File: bcs_boot_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - pin zero level captured into status bit 7 on the same clock edge that raises the crystal enable
// - factory load error code lands in status bits 4 to 2, zero means success
// - a failing second or later user block sets status bit 1
// - a failing first user block sets status bit 0
// - fail flag, bit 2, set when status byte is nonzero, apart from done
// - done flag, bit 1, always set when boot finishes
// - run bit set at boot end makes the core start at RAM address zero
// - run bits obeyed only for factory and user levels, ignored at run level
// - force bit on a user part loads only factory values, no user blocks
// - force bit overrides the user-continue bit on a user part only
// - power-on run bit acts exactly like the system run bit
// - writing 0x20 on a user part keeps factory behaviour over restarts until power-on reset
// - status 0x00 or 0x80 means clean boot, anything else is an error
module bcs_boot_ctrl #(
  parameter logic [1:0] SAMPLE_WAIT = bcs_pkg::STRAP_WAIT
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        sys_rst_req,
  input  wire logic        general_pin_zero,
  input  wire logic [1:0]  prog_state,
  input  wire logic        user_continue_bit,
  output logic             load_req,
  output logic [1:0]       load_kind,
  input  wire logic        load_ack,
  input  wire logic [2:0]  load_err,
  input  wire logic        more_blocks,
  output logic             crystal_osc_en,
  output logic             cpu_release,
  output logic             jump_to_ram,
  output logic [15:0]      jump_addr,
  output logic             boot_ok,
  output logic             boot_done_flag,
  output logic             boot_fail_flag,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_we,
  input  wire logic [7:0]  sfr_wdata,
  output logic [7:0]       sfr_rdata,
  input  wire logic [15:0] xdata_addr,
  output logic [7:0]       xdata_rdata
);
  import bcs_pkg::*;

  typedef enum logic [2:0] {
    S_SAMPLE,
    S_FACTORY,
    S_USER,
    S_FINISH,
    S_RUN
  } bcs_state_t;

  typedef struct packed {
    bcs_state_t  st;
    logic [1:0]  wait_cnt;
    logic [7:0]  stat;
    logic        xtal;
    logic [1:0]  kind;
    logic        release_core;
    logic        jump;
    logic [15:0] addr;
    logic        ok;
    logic [7:0]  xrd;
  } bcs_core_t;

  bcs_core_t q;
  bcs_core_t d;
  logic      pin_s;
  logic      force_active;
  logic      load_user;
  logic      run_bits;
  logic      jump_now;
  logic      stat_clean;

  bcs_reg_if rif ();

  // refuse a strap delay shorter than the synchroniser
  if (SAMPLE_WAIT < 2'(SYNC_STAGES)) begin : g_chk
    $error("SAMPLE_WAIT shorter than pin synchroniser");
  end

  // pin zero comes from outside, two flops before use
  bcs_sync u_sync (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .ce       (ce),
    .pin_in   (general_pin_zero),
    .pin_sync (pin_s)
  );

  // boot flag register on the special-function bus
  bcs_sfr u_sfr (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .ce        (ce),
    .sfr_addr  (sfr_addr),
    .sfr_we    (sfr_we),
    .sfr_wdata (sfr_wdata),
    .sfr_rdata (sfr_rdata),
    .rif       (rif.regs)
  );

  // boot policy decoded from level, flags and protection byte
  assign force_active = rif.flags[FL_FORCE] && (prog_state == PROG_USER);
  assign load_user    = (prog_state != PROG_FACTORY) && !force_active;
  assign run_bits     = rif.flags[FL_RUN_SYS] | rif.flags[FL_RUN_POR];
  assign jump_now     = ((prog_state != PROG_RUN) && run_bits)
                      || (!force_active && user_continue_bit && (prog_state != PROG_FACTORY));
  assign stat_clean   = (q.stat == STAT_OK_PLAIN) || (q.stat == STAT_OK_STRAP);

  // boot sequencer: strap, factory load, user blocks, finish
  always_comb begin
    d     = q;
    d.xrd = (xdata_addr == XD_STAT_ADDR) ? q.stat : 8'h00;
    if (sys_rst_req) begin
      d     = '0; // restart the whole boot
      d.xrd = 8'h00;
    end else begin
      case (q.st)
        S_SAMPLE: begin
          if (q.wait_cnt >= SAMPLE_WAIT) begin
            d.stat[ST_STRAP] = pin_s;
            d.xtal           = 1'b1;
            d.kind           = LOAD_FACTORY;
            d.st             = S_FACTORY;
          end else begin
            d.wait_cnt = q.wait_cnt + 2'h1;
          end
        end
        S_FACTORY: begin
          if (load_ack) begin
            d.stat[ST_FAC_MSB:ST_FAC_LSB] = load_err;
            if (load_user) begin
              d.kind = LOAD_FIRST;
              d.st   = S_USER;
            end else begin
              d.st = S_FINISH;
            end
          end
        end
        S_USER: begin
          if (load_ack) begin
            if (load_err != 3'h0) begin
              if (q.kind == LOAD_FIRST) begin
                d.stat[ST_FIRST_ERR] = 1'b1;
              end else begin
                d.stat[ST_NEXT_ERR] = 1'b1;
              end
            end
            if (more_blocks) begin
              d.kind = LOAD_NEXT;
            end else begin
              d.st = S_FINISH;
            end
          end
        end
        S_FINISH: begin
          d.release_core = 1'b1;
          d.jump         = jump_now;
          d.addr         = RAM_ENTRY_ADDR;
          d.ok           = stat_clean;
          d.st           = S_RUN;
        end
        S_RUN: begin
          d.st = S_RUN; // results held until reset
        end
        default: begin
          d.st = S_SAMPLE;
        end
      endcase
    end
  end

  // single state register, frozen while ce is low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // requests to the flag register
  assign rif.done_set = (q.st == S_FINISH);
  assign rif.fail_set = (q.st == S_FINISH) && (q.stat != STAT_OK_PLAIN);
  assign rif.restart  = sys_rst_req;

  // outward signals
  assign load_req       = (q.st == S_FACTORY) || (q.st == S_USER);
  assign load_kind      = q.kind;
  assign crystal_osc_en = q.xtal;
  assign cpu_release    = q.release_core;
  assign jump_to_ram    = q.jump;
  assign jump_addr      = q.addr;
  assign boot_ok        = q.ok;
  assign boot_done_flag = rif.flags[FL_DONE];
  assign boot_fail_flag = rif.flags[FL_FAIL];
  assign xdata_rdata    = q.xrd;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  strap_capture_a: assert property (
    ce && !sys_rst_req && q.st == S_SAMPLE && q.wait_cnt >= SAMPLE_WAIT
    |=> q.stat[ST_STRAP] == $past(pin_s) && crystal_osc_en)
    else $error("strap not captured at boot start");
  xtal_late_a: assert property (
    q.st == S_SAMPLE |-> !crystal_osc_en)
    else $error("crystal enabled before strap sample");
  factory_err_a: assert property (
    ce && !sys_rst_req && q.st == S_FACTORY && load_ack
    |=> q.stat[ST_FAC_MSB:ST_FAC_LSB] == $past(load_err))
    else $error("factory error field wrong");
  later_err_a: assert property (
    ce && !sys_rst_req && q.st == S_USER && load_ack && load_err != 3'h0 && q.kind == LOAD_NEXT
    |=> q.stat[ST_NEXT_ERR])
    else $error("later block error not flagged");
  first_err_a: assert property (
    ce && !sys_rst_req && q.st == S_USER && load_ack && load_err != 3'h0 && q.kind == LOAD_FIRST
    |=> q.stat[ST_FIRST_ERR])
    else $error("first block error not flagged");
  fail_flag_a: assert property (
    ce && !sys_rst_req && q.st == S_FINISH && q.stat != STAT_OK_PLAIN |=> boot_fail_flag)
    else $error("fail flag missing");
  done_flag_a: assert property (
    ce && !sys_rst_req && q.st == S_FINISH |=> boot_done_flag && cpu_release)
    else $error("done flag missing at boot end");
  ram_jump_a: assert property (
    ce && !sys_rst_req && q.st == S_FINISH && prog_state != PROG_RUN && run_bits
    |=> jump_to_ram && jump_addr == RAM_ENTRY_ADDR)
    else $error("run bit did not select RAM entry");
  run_ignored_a: assert property (
    ce && !sys_rst_req && q.st == S_FINISH && prog_state == PROG_RUN && !user_continue_bit
    |=> !jump_to_ram)
    else $error("run bit obeyed at run level");
  force_stop_a: assert property (
    ce && !sys_rst_req && q.st == S_FACTORY && load_ack && force_active
    |=> q.st == S_FINISH)
    else $error("user blocks loaded despite force bit");
  status_hold_a: assert property (
    q.st == S_RUN && !sys_rst_req |=> $stable(q.stat) && q.st == S_RUN)
    else $error("status changed after boot");

  // restart and clock-enable behaviour of the sequencer
  restart_clear_a: assert property (
    ce && sys_rst_req |=> q.st == S_SAMPLE && q.stat == STAT_RST && !cpu_release && !jump_to_ram)
    else $error("system restart left boot results behind");
  freeze_all_a: assert property (
    !ce |=> $stable(q) && $stable(rif.flags))
    else $error("state moved while clock enable low");
  xtal_rise_a: assert property (
    $rose(crystal_osc_en) |-> q.st == S_FACTORY && load_kind == LOAD_FACTORY)
    else $error("crystal enabled outside strap capture");

  // load ordering: factory first, then the first user block, then later ones
  first_kind_a: assert property (
    ce && !sys_rst_req && q.st == S_FACTORY && load_ack && load_user
    |=> load_req && load_kind == LOAD_FIRST)
    else $error("first user block not requested after factory load");
  next_kind_a: assert property (
    ce && !sys_rst_req && q.st == S_USER && load_ack && more_blocks
    |=> load_req && load_kind == LOAD_NEXT)
    else $error("later user block not requested");
  factory_kind_a: assert property (
    q.st == S_FACTORY |-> load_req && load_kind == LOAD_FACTORY)
    else $error("factory load not requested first");

  // run policy and clean report at boot end
  por_run_a: assert property (
    ce && !sys_rst_req && q.st == S_FINISH && prog_state != PROG_RUN && rif.flags[FL_RUN_POR]
    |=> jump_to_ram && jump_addr == RAM_ENTRY_ADDR)
    else $error("power-on run bit not obeyed");
  force_over_a: assert property (
    ce && !sys_rst_req && q.st == S_FINISH && force_active && user_continue_bit && !run_bits
    |=> !jump_to_ram)
    else $error("continue bit overrode force bit");
  boot_ok_a: assert property (
    ce && !sys_rst_req && q.st == S_FINISH
    |=> boot_ok == ($past(q.stat) == STAT_OK_PLAIN || $past(q.stat) == STAT_OK_STRAP))
    else $error("clean boot report wrong");
  clean_fail_a: assert property (
    ce && !sys_rst_req && q.st == S_FINISH && q.stat == STAT_OK_PLAIN && !boot_fail_flag
    |=> !boot_fail_flag)
    else $error("fail flag set on clean boot");

  // results stay put after boot end
  done_hold_a: assert property (
    boot_done_flag && !sys_rst_req |=> boot_done_flag)
    else $error("done flag dropped before reset");
  fail_hold_a: assert property (
    boot_fail_flag && !sys_rst_req |=> boot_fail_flag)
    else $error("fail flag dropped before reset");
  stat_read_a: assert property (
    ce && !sys_rst_req && xdata_addr == XD_STAT_ADDR |=> xdata_rdata == $past(q.stat))
    else $error("status byte read wrong");
  release_hold_a: assert property (
    cpu_release && !sys_rst_req |=> cpu_release && jump_addr == RAM_ENTRY_ADDR)
    else $error("core release dropped before reset");
endmodule
`default_nettype wire

// File: bcs_nvm_model.sv
`timescale 1ns/10ps
`default_nettype none
module bcs_nvm_model (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       load_req,
  input  wire logic [1:0] load_kind,
  input  wire logic [2:0] err_fac,
  input  wire logic [2:0] err_usr1,
  input  wire logic [2:0] err_usrn,
  input  wire logic [3:0] n_blocks,
  input  wire logic [7:0] delay,
  output logic            load_ack,
  output logic [2:0]      load_err,
  output logic            more_blocks
);
  import bcs_pkg::*;
  logic [7:0] wait_q;
  logic [3:0] blk_q;
  // answers each load after delay cycles; outside the ack pulse the data lines keep toggling
  always @(negedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wait_q      <= 8'h00;
      blk_q       <= 4'h0;
      load_ack    <= 1'b0;
      load_err    <= 3'h0;
      more_blocks <= 1'b0;
    end else if (load_req && !load_ack && wait_q == delay) begin
      load_ack    <= 1'b1;
      wait_q      <= 8'h00;
      load_err    <= (load_kind == LOAD_FACTORY) ? err_fac : (load_kind == LOAD_FIRST) ? err_usr1 : err_usrn;
      more_blocks <= (load_kind != LOAD_FACTORY) && (blk_q + 4'h1 < n_blocks);
      blk_q       <= (load_kind == LOAD_FACTORY) ? 4'h0 : blk_q + 4'h1;
    end else begin
      load_ack    <= 1'b0;
      load_err    <= ~load_err;
      more_blocks <= ~more_blocks;
      wait_q      <= (load_req && !load_ack) ? wait_q + 8'h01 : 8'h00;
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import bcs_pkg::*;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic        sys_rst_req = 1'b0;
  logic        general_pin_zero = 1'b0;
  logic [1:0]  prog_state = PROG_FACTORY;
  logic        user_continue_bit = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_we = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [15:0] xdata_addr = 16'h0000;
  logic [2:0]  err_fac = 3'h0;
  logic [2:0]  err_usr1 = 3'h0;
  logic [2:0]  err_usrn = 3'h0;
  logic [3:0]  n_blocks = 4'h1;
  logic [7:0]  delay = 8'h10;
  logic        load_req, load_ack, more_blocks, crystal_osc_en, cpu_release;
  logic        jump_to_ram, boot_ok, boot_done_flag, boot_fail_flag;
  logic [1:0]  load_kind;
  logic [2:0]  load_err;
  logic [15:0] jump_addr;
  logic [7:0]  sfr_rdata, xdata_rdata, fl_exp;
  logic [15:0] acks [3];
  int          bad_count = 0;
  int          n_tests = 0;
  always #4 clk_sys = ~clk_sys;
  bcs_boot_ctrl DUT (.clk_sys, .nrst, .ce, .sys_rst_req, .general_pin_zero, .prog_state, .user_continue_bit,
    .load_req, .load_kind, .load_ack, .load_err, .more_blocks, .crystal_osc_en, .cpu_release, .jump_to_ram,
    .jump_addr, .boot_ok, .boot_done_flag, .boot_fail_flag, .sfr_addr, .sfr_we, .sfr_wdata, .sfr_rdata,
    .xdata_addr, .xdata_rdata);
  bcs_nvm_model nvm (.clk_sys, .nrst, .load_req, .load_kind, .err_fac, .err_usr1, .err_usrn, .n_blocks,
    .delay, .load_ack, .load_err, .more_blocks);
  // counts accepted loads of each kind
  always @(posedge clk_sys) if (load_ack && load_req && ce) acks[load_kind] <= acks[load_kind] + 16'h0001;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // bus tasks start and end at a falling edge
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    @(negedge clk_sys);
    d = sfr_rdata;
  endtask
  task automatic xd_rd(input logic [15:0] a, output logic [7:0] d);
    xdata_addr = a;
    @(negedge clk_sys);
    d = xdata_rdata;
  endtask
  task automatic sfr_wr(input logic [7:0] v);
    sfr_addr = SFR_FLAGS_ADDR;
    sfr_wdata = v;
    sfr_we = 1'b1;
    @(negedge clk_sys);
    sfr_we = 1'b0;
    fl_exp = (fl_exp & ~FLAGS_SW_MASK) | (v & FLAGS_SW_MASK);
    @(negedge clk_sys);
  endtask
  // restarts boot, optionally writes the flags mid-boot, then judges every boot result
  task automatic boot(input logic [1:0] lvl, input logic strap, input logic uc, input logic [2:0] ef,
                      input logic [2:0] e1, input logic [2:0] en, input logic [3:0] nb, input logic por,
                      input logic [7:0] dl, input logic wen, input logic [7:0] wv);
    logic       ul, fa, jmp;
    logic [7:0] st, d;
    prog_state = lvl;
    general_pin_zero = strap;
    user_continue_bit = uc;
    {err_fac, err_usr1, err_usrn, n_blocks, delay} = {ef, e1, en, nb, dl};
    acks = '{16'h0000, 16'h0000, 16'h0000};
    if (por) nrst = 1'b0;
    else sys_rst_req = 1'b1;
    @(negedge clk_sys);
    nrst = 1'b1;
    sys_rst_req = 1'b0;
    fl_exp = por ? FLAGS_RST : fl_exp & FORCE_VALUE;
    repeat (4) @(negedge clk_sys);
    if (wen) sfr_wr(wv);
    fa = fl_exp[FL_FORCE] && lvl == PROG_USER;
    ul = lvl != PROG_FACTORY && !fa;
    st = {strap, 2'b00, ef, ul && nb > 4'h1 && en != 3'h0, ul && e1 != 3'h0};
    jmp = (lvl != PROG_RUN && (fl_exp[FL_RUN_SYS] || fl_exp[FL_RUN_POR])) || (!fa && uc && lvl != PROG_FACTORY);
    fl_exp = fl_exp | {5'h00, st != 8'h00, 2'b10};
    for (int i = 0; i < 3000 && cpu_release !== 1'b1; i++) @(negedge clk_sys);
    repeat (30) @(negedge clk_sys);
    xd_rd(XD_STAT_ADDR, d);
    chk("status byte", {8'h00, st}, {8'h00, d});
    sfr_rd(SFR_FLAGS_ADDR, d);
    chk("flags", {8'h00, fl_exp}, {8'h00, d});
    chk1("done flag", 1'b1, boot_done_flag);
    chk1("crystal enable", 1'b1, crystal_osc_en);
    chk1("cpu release", 1'b1, cpu_release);
    chk1("fail flag", st != 8'h00, boot_fail_flag);
    chk1("boot_ok", st == STAT_OK_PLAIN || st == STAT_OK_STRAP, boot_ok);
    chk1("jump_to_ram", jmp, jump_to_ram);
    if (jmp) chk("jump_addr", RAM_ENTRY_ADDR, jump_addr);
    chk("factory loads", 16'h0001, acks[0]);
    chk("user loads", ul ? {12'h000, nb} : 16'h0000, acks[1] + acks[2]);
  endtask
  task automatic t_reset;
    logic [7:0] d;
    sfr_rd(SFR_FLAGS_ADDR, d);
    chk("flags after reset", {8'h00, FLAGS_RST}, {8'h00, d});
  endtask
  task automatic t_factory_clean;
    boot(PROG_FACTORY, 1'b1, 1'b1, 3'h0, 3'h0, 3'h0, 4'h2, 1'b1, 8'h10, 1'b0, 8'h00);
  endtask
  task automatic t_user_errors;
    boot(PROG_USER, 1'b0, 1'b0, 3'h5, 3'h1, 3'h6, 4'h3, 1'b0, 8'h00, 1'b0, 8'h00);
  endtask
  task automatic t_run_bits;
    for (int i = 0; i < 4; i++) begin
      boot(i[1] ? PROG_RUN : PROG_USER, 1'b0, 1'b0, 3'h0, 3'h0, 3'h0, 4'h1, 1'b0, 8'h10, 1'b1,
           i[0] ? 8'h10 : 8'h01);
    end
  endtask
  task automatic t_force;
    sfr_wr(FORCE_VALUE);
    boot(PROG_USER, 1'b0, 1'b1, 3'h0, 3'h1, 3'h1, 4'h2, 1'b0, 8'h10, 1'b0, 8'h00);
    boot(PROG_USER, 1'b1, 1'b1, 3'h0, 3'h1, 3'h1, 4'h2, 1'b0, 8'h10, 1'b0, 8'h00);
    boot(PROG_USER, 1'b0, 1'b1, 3'h0, 3'h0, 3'h0, 4'h2, 1'b1, 8'h10, 1'b0, 8'h00);
  endtask
  task automatic t_refused;
    logic [7:0] d;
    sfr_wr(8'hFF);
    sfr_rd(SFR_FLAGS_ADDR, d);
    chk("flags after full write", {8'h00, fl_exp}, {8'h00, d});
    sfr_rd(8'h3C, d);
    chk("unmapped sfr", 16'h0000, {8'h00, d});
    xd_rd(16'h11FE, d);
    chk("unmapped xdata", 16'h0000, {8'h00, d});
  endtask
  // a write offered while the clock enable is low must not land
  task automatic t_freeze;
    logic [7:0] e, d;
    e = fl_exp;
    ce = 1'b0;
    sfr_wr(8'h00);
    ce = 1'b1;
    fl_exp = e;
    sfr_rd(SFR_FLAGS_ADDR, d);
    chk("flags with ce low", {8'h00, e}, {8'h00, d});
  endtask
  initial begin
    #400000;
    bad_count++;
    final_report;
  end
  initial begin
    fl_exp = FLAGS_RST;
    repeat (20) @(negedge clk_sys);
    nrst = 1'b1;
    t_reset;
    t_factory_clean;
    t_user_errors;
    t_run_bits;
    t_force;
    t_refused;
    t_freeze;
    final_report;
  end
endmodule
`default_nettype wire
